// file: verif/icr_slave_model.sv
// far-side slave: acknowledges the first byte after each START
// assumes resolved open-drain wires with pull-ups
`timescale 1ns/10ps
module icr_slave_model (
	input  wire logic scl,
	input  wire logic sda,
	output logic      pull
);
	int   cnt;
	logic act;
	// idle until a START frames a byte
	initial
	begin
		cnt = 0;
		act = 0;
		pull = 0;
	end
	// start seen: arm the bit counter
	always @(negedge sda)
		if (scl)
		begin
			act = 1;
			cnt = 0;
		end
	// stop seen: let go of the line
	always @(posedge sda)
		if (scl)
		begin
			act = 0;
			pull = 0;
		end
	// ninth clock low only; later bytes get no ack, like a picky slave
	always @(negedge scl)
		if (act)
		begin
			cnt++;
			pull = (cnt == 9);
			if (cnt == 10)
				act = 0;
		end
endmodule : icr_slave_model

// file: verif/test_icr_ctrl.sv
// bench for the bus control block: apb tasks, pin monitor, scenarios
// assumes the slave model on the pins and pull-ups on both lines
`timescale 1ns/10ps
module test_icr_ctrl;
	import icr_pkg::*;
	logic        clk_sys, nrst, psel, penable, pwrite, e;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, scl_o, scl_oe, sda_o, sda_oe;
	logic        irq_req, s_pull, x_pull, sda_d, scl_d;
	int          n_mismatch, checks, n_start, n_stop;
	// open-drain wires, x_pull plays another master
	wire scl = ~(scl_oe & ~scl_o);
	wire sda = ~((sda_oe & ~sda_o) | s_pull | x_pull);

	icr_ctrl i_dut (.clk_sys(clk_sys), .nrst(nrst), .ce(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
		.scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
		.sda_oe(sda_oe), .irq_req(irq_req));
	icr_slave_model i_slv (.scl(scl), .sda(sda), .pull(s_pull));

	initial
	begin
		clk_sys = 0;
		forever #50 clk_sys = ~clk_sys;
	end
	// count START and STOP as seen on the wires
	always @(posedge clk_sys)
	begin
		sda_d <= sda;
		scl_d <= scl;
		if (scl && scl_d && sda_d && !sda)
			n_start <= n_start + 1;
		if (scl && scl_d && !sda_d && sda)
			n_stop <= n_stop + 1;
	end
	////////////////////////////////////////
	task close_out;
		$display("checks %0d n_mismatch %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : close_out
	task chk(input logic [7:0] got, input logic [7:0] exp);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// one apb transfer, held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1;
		@(posedge clk_sys);
		while (pready !== 1'b1)
		begin
			if (++n > 50)
			begin
				n_mismatch++;
				close_out;
			end
			@(posedge clk_sys);
		end
		q = prdata;
		e = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk_sys);
	endtask : apb
	// poll a status bit, bounded
	task wst(input int b, input logic v);
		int n;
		n = 0;
		apb(0, OFS_STATUS, 0);
		while (q[b] !== v)
		begin
			if (++n > 900)
			begin
				n_mismatch++;
				close_out;
			end
			apb(0, OFS_STATUS, 0);
		end
	endtask : wst
	////////////////////////////////////////
	initial
	begin
		nrst = 0;
		{psel, penable, pwrite, paddr, pwdata, x_pull} = 0;
		{n_mismatch, checks, n_start, n_stop} = 0;
		{sda_d, scl_d} = 2'b11;
		repeat (2) @(posedge clk_sys);
		nrst <= 1;
		repeat (3) @(posedge clk_sys);
		apb(0, OFS_CONTROL, 0);
		chk(q[7:0], RST_CONTROL);
		apb(0, 8'h04, 0);
		chk({7'h00, e}, 8'h01);
		// disabled: bits stored, repeat and reserved read zero, bus quiet
		apb(1, OFS_CONTROL, 32'h0000_007F);
		apb(0, OFS_CONTROL, 0);
		chk(q[7:0], 8'h78);
		repeat (200) @(posedge clk_sys);
		chk({n_start[5:0], scl_oe, sda_oe}, 8'h00);
		chk({6'h00, scl_o, sda_o}, 8'h00);
		apb(1, OFS_CONTROL, 0);
		$display("test disabled done");
		// address byte as master transmitter
		apb(1, OFS_CONTROL, 32'h0000_0080);
		apb(1, OFS_DATA, 32'h0000_00A0);
		apb(1, OFS_CONTROL, 32'h0000_00B0);
		wst(BIT_IRQ_PEND, 1);
		chk(q[7:0], 8'hA2);
		chk(n_start[7:0], 8'h01);
		chk({7'h00, irq_req}, 8'h00);
		apb(1, OFS_CONTROL, 32'h0000_00F0);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, irq_req}, 8'h01);
		apb(1, OFS_CONTROL, 32'h0000_00B0);
		repeat (2) @(posedge clk_sys);
		chk({7'h00, irq_req}, 8'h00);
		apb(0, OFS_STATUS, 0);
		chk({7'h00, q[BIT_IRQ_PEND]}, 8'h01);
		apb(1, OFS_STATUS, 0);
		apb(1, OFS_CONTROL, 32'h0000_0080);
		wst(BIT_BUSY, 0);
		chk(n_stop[7:0], 8'h01);
		$display("test master done");
		// repeat start without owning the bus
		apb(1, OFS_CONTROL, 32'h0000_0084);
		wst(BIT_ARB_LOST, 1);
		chk({7'h00, q[BIT_IRQ_PEND]}, 8'h01);
		apb(0, OFS_CONTROL, 0);
		chk(q[7:0], 8'h80);
		apb(1, OFS_STATUS, 0);
		$display("test repeat done");
		// another master holds the bus; our start must lose quietly
		x_pull <= 1;
		wst(BIT_BUSY, 1);
		apb(1, OFS_CONTROL, 32'h0000_00B0);
		wst(BIT_ARB_LOST, 1);
		apb(0, OFS_CONTROL, 0);
		chk(q[7:0], 8'h90);
		repeat (20) @(posedge clk_sys);
		chk({n_stop[5:0], scl_oe, sda_oe}, 8'h04);
		x_pull <= 0;
		wst(BIT_BUSY, 0);
		$display("test busy done");
		close_out;
	end
endmodule : test_icr_ctrl

// file: verilog/icr_ctrl.sv
// bus control block: APB registers, transmit buffer, master sequencer and byte engine
// assumes open-drain pins resolved outside, pins asynchronous to clk_sys
// How it works
// R1: enable low resets engine, registers stay accessible
// R2: control bits act only while enabled
// R3: slave waits for next START after enable
// R4: master ignores traffic seen before enable
// R5: clearing interrupt enable keeps pending flag
// R6: interrupt only when enable and pending
// R7: arbitration loss clears master, no STOP
// R8: master bit falling issues STOP
// R9: master bit rising issues START
// R10: transmit bit sets direction, 1 transmits
// R11: software matches direction to slave flag
// R12: acknowledge bit sets ninth-clock data level
// R13: acknowledge bit used only when receiving
// R14: repeat start request, reads zero
// R15: repeat start without ownership loses arbitration
// R16: busy set on START, cleared on STOP
// R17: START while busy loses arbitration
// R18: pending set at ninth clock, match, loss
// R19: reserved bit and repeat bit read zero
`timescale 1ns/10ps

////////////////////////////////////////////////////////////////////////////////
// small synchronous FIFO with valid/ready on both sides
module icr_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             ce,
	input  wire logic             flush,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wp_r;
	logic [AW-1:0]    rp_r;
	logic [AW:0]      cnt_r;
	logic             push;
	logic             pop;

	assign in_ready  = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign out_data  = mem[rp_r];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;

	// pointers wrap at the power-of-two depth
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wp_r  <= '0;
			rp_r  <= '0;
			cnt_r <= '0;
		end
		else if (ce)
		begin
			if (flush)
			begin
				wp_r  <= '0;
				rp_r  <= '0;
				cnt_r <= '0;
			end
			else
			begin
				if (push)
					wp_r <= wp_r + 1'b1;
				if (pop)
					rp_r <= rp_r + 1'b1;
				cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
			end
		end
	end

	// storage has no reset, only valid words are ever read
	always_ff @(posedge clk)
	begin
		if (ce && push)
			mem[wp_r] <= in_data;
	end
endmodule : icr_fifo

////////////////////////////////////////////////////////////////////////////////
module icr_ctrl (
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	input  wire logic        ce,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe,
	output logic             irq_req
);
	import icr_pkg::*;

	logic rst_m_r, rst_n;
	logic scl_m_r, scl_s_r, scl_d_r, sda_m_r, sda_s_r, sda_d_r;
	logic [7:0] ctrl_r, own_addr_r, rx_data_r;
	logic en, ie, ms, xmit_sel, ack_sup;
	logic pready_r, pslverr_r, sda_out_r, scl_out_r;
	logic [31:0] prdata_r;
	logic acc, wr_fire, rd_fire, ctrl_wr, stat_wr, data_wr;
	logic start_req_r, stop_req_r, rs_req_r, rx_req_r;
	logic busy_r, arb_lost_r, pend_r, addressed_r, slv_dir_r, rx_ack_r;
	logic [3:0] bit_cnt_r;
	logic [7:0] sh_r, tmr_r;
	logic eng_low_r, tx_loaded_r, in_addr_r, addr_hit_r, byte_act_r;
	logic scl_rise, scl_fall, start_det, stop_det;
	logic active, xmit, byte_done, arb_evt, arb_data, start_busy;
	logic f_valid, f_ready, f_pop;
	logic [7:0] f_data;
	logic mst_scl_low_r, mst_sda_low_r, stretch, irq_r;
	icr_mstate_t mst_r;

	// reset release through two flops, assertion stays asynchronous
	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			rst_m_r <= 1'b0;
			rst_n   <= 1'b0;
		end
		else
		begin
			rst_m_r <= 1'b1;
			rst_n   <= rst_m_r;
		end
	end

	// pin synchronisers, a third stage only for edge finding
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			{scl_m_r, scl_s_r, scl_d_r} <= 3'b111;
			{sda_m_r, sda_s_r, sda_d_r} <= 3'b111;
		end
		else if (ce)
		begin
			{scl_m_r, scl_s_r, scl_d_r} <= {scl_i, scl_m_r, scl_s_r};
			{sda_m_r, sda_s_r, sda_d_r} <= {sda_i, sda_m_r, sda_s_r};
		end
	end

	assign scl_rise  = scl_s_r && !scl_d_r;
	assign scl_fall  = !scl_s_r && scl_d_r;
	assign start_det = en && scl_s_r && scl_d_r && !sda_s_r && sda_d_r;
	assign stop_det  = en && scl_s_r && scl_d_r && sda_s_r && !sda_d_r;

	// interrupt enable and master select are qualified by the module enable
	assign en       = ctrl_r[BIT_MOD_EN];
	assign ie       = en && ctrl_r[BIT_IRQ_EN];                // R2
	assign ms       = en && ctrl_r[BIT_MST_SEL];               // R2
	assign xmit_sel = ctrl_r[BIT_TX_SEL];
	assign ack_sup  = ctrl_r[BIT_ACK_SUP];

	////////////////////////////////////////////////////////////////////////////
	// APB slave: one wait state, data writes stall while the buffer is full
	assign acc     = psel && penable && pready_r;
	assign wr_fire = acc && pwrite && !pslverr_r;
	assign rd_fire = acc && !pwrite && !pslverr_r;
	assign ctrl_wr = wr_fire && (paddr == OFS_CONTROL);
	assign stat_wr = wr_fire && (paddr == OFS_STATUS);
	assign data_wr = wr_fire && (paddr == OFS_DATA);

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0000_0000;
		end
		else if (ce)
		begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			if (psel && penable && !pready_r && !(pwrite && paddr == OFS_DATA && !f_ready))
			begin
				pready_r  <= 1'b1;
				pslverr_r <= !(paddr inside {OFS_OWN_ADDR, OFS_CONTROL, OFS_STATUS, OFS_DATA});
				unique case (paddr)
					OFS_OWN_ADDR: prdata_r <= {24'h00_0000, own_addr_r[7:1], 1'b0};
					OFS_CONTROL:  prdata_r <= {24'h00_0000, ctrl_r[7:3], 3'b000}; // R14 R19
					OFS_STATUS:   prdata_r <= {24'h00_0000, !byte_act_r, addressed_r, busy_r,
					                           arb_lost_r, 1'b0, slv_dir_r, pend_r, rx_ack_r};
					OFS_DATA:     prdata_r <= {24'h00_0000, rx_data_r};
					default:      prdata_r <= 32'h0000_0000;
				endcase
			end
		end
	end

	// control register, master bit also cleared by arbitration loss
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl_r     <= RST_CONTROL;
			own_addr_r <= RST_OWN_ADDR;
		end
		else if (ce)
		begin
			if (ctrl_wr)
				ctrl_r <= {pwdata[7:3], 3'b000};                   // R1 R10 R19
			if (wr_fire && paddr == OFS_OWN_ADDR)
				own_addr_r <= {pwdata[7:1], 1'b0};
			if (arb_evt)
				ctrl_r[BIT_MST_SEL] <= 1'b0;                       // R7
		end
	end

	// requests for the sequencer, taken from control writes and data reads while enabled
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			start_req_r <= 1'b0;
			stop_req_r  <= 1'b0;
			rs_req_r    <= 1'b0;
			rx_req_r    <= 1'b0;
		end
		else if (ce)
		begin
			if (!en || arb_evt)
			begin
				start_req_r <= 1'b0;
				stop_req_r  <= 1'b0;
				rs_req_r    <= 1'b0;
				rx_req_r    <= 1'b0;
			end
			else
			begin
				if (ctrl_wr && pwdata[BIT_MST_SEL] && !ctrl_r[BIT_MST_SEL])
					start_req_r <= 1'b1;                           // R9
				else if (mst_r == M_IDLE)
					start_req_r <= 1'b0;
				if (ctrl_wr && !pwdata[BIT_MST_SEL] && ctrl_r[BIT_MST_SEL])
					stop_req_r <= 1'b1;                            // R8
				else if (mst_r == M_STOP1)
					stop_req_r <= 1'b0;
				if (ctrl_wr && pwdata[BIT_RS_CMD] && ms)
					rs_req_r <= 1'b1;                              // R14
				else if (mst_r == M_RS1)
					rs_req_r <= 1'b0;
				// reading the data register lets the master clock in one more byte
				if (rd_fire && paddr == OFS_DATA && ms && !xmit_sel)
					rx_req_r <= 1'b1;
				else if (byte_done)
					rx_req_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit buffer between data writes and the shifter
	icr_fifo #(
		.WIDTH (FIFO_WIDTH),
		.DEPTH (FIFO_DEPTH)
	) u_txq (
		.clk       (clk_sys),
		.rst_n     (rst_n),
		.ce        (ce),
		.flush     (!en),
		.in_valid  (data_wr),
		.in_ready  (f_ready),
		.in_data   (pwdata[7:0]),
		.out_valid (f_valid),
		.out_ready (f_pop),
		.out_data  (f_data)
	);

	assign active    = ms || addressed_r || in_addr_r;
	assign xmit      = xmit_sel && !in_addr_r;                                   // R10
	assign f_pop     = active && xmit && bit_cnt_r == 4'h0 && !scl_s_r && !tx_loaded_r && f_valid;
	assign byte_done = active && scl_fall && bit_cnt_r == BITS_BYTE;
	// released data bit read back low means another master won
	assign arb_data   = ms && xmit && scl_rise && bit_cnt_r < BITS_DATA && !eng_low_r && !sda_s_r;
	assign start_busy = en && start_req_r && mst_r == M_IDLE && busy_r;          // R17
	assign arb_evt    = arb_data || start_busy || (ctrl_wr && pwdata[BIT_RS_CMD] && !ms && en); // R15

	// bus busy follows START and STOP; cleared while disabled so master is unaware
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			busy_r <= 1'b0;
		else if (ce)
		begin
			if (!en)
				busy_r <= 1'b0;                                    // R4
			else if (start_det)
				busy_r <= 1'b1;                                    // R16
			else if (stop_det)
				busy_r <= 1'b0;                                    // R16
		end
	end

	// byte engine: samples on scl rise, drives data on scl fall
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bit_cnt_r   <= 4'h0;
			sh_r        <= 8'h00;
			eng_low_r   <= 1'b0;
			tx_loaded_r <= 1'b0;
			in_addr_r   <= 1'b0;
			addr_hit_r  <= 1'b0;
			addressed_r <= 1'b0;
			slv_dir_r   <= 1'b0;
			rx_ack_r    <= 1'b0;
			rx_data_r   <= 8'h00;
			byte_act_r  <= 1'b0;
		end
		else if (ce)
		begin
			if (!en)
			begin
				bit_cnt_r   <= 4'h0;                               // R1
				eng_low_r   <= 1'b0;
				tx_loaded_r <= 1'b0;
				in_addr_r   <= 1'b0;
				addressed_r <= 1'b0;
				byte_act_r  <= 1'b0;
			end
			else if (start_det)
			begin
				bit_cnt_r   <= 4'h0;
				in_addr_r   <= !ms;                                // R3
				addressed_r <= 1'b0;
				eng_low_r   <= 1'b0;
				tx_loaded_r <= 1'b0;
				byte_act_r  <= 1'b0;
			end
			else
			begin
				if (ctrl_wr)
					addressed_r <= 1'b0;
				if (f_pop)
				begin
					sh_r        <= f_data;
					tx_loaded_r <= 1'b1;
					eng_low_r   <= !f_data[7];
				end
				if (scl_rise && bit_cnt_r < BITS_BYTE)
				begin
					if (bit_cnt_r < BITS_DATA)
						sh_r <= {sh_r[6:0], sda_s_r};
					else
						rx_ack_r <= sda_s_r;
					if (bit_cnt_r == BITS_DATA - 4'h1 && in_addr_r)
						addr_hit_r <= (sh_r[6:0] == own_addr_r[7:1]);
					bit_cnt_r <= bit_cnt_r + 4'h1;
					// transfer-complete status drops while a byte is on the wire
					if (active)
						byte_act_r <= 1'b1;
				end
				if (scl_fall && active)
				begin
					if (bit_cnt_r == BITS_DATA)
						// ninth clock: address match, or receiver honours ack bit
						eng_low_r <= in_addr_r ? addr_hit_r : (!xmit && !ack_sup); // R12 R13
					else if (byte_done)
					begin
						bit_cnt_r   <= 4'h0;
						eng_low_r   <= 1'b0;
						tx_loaded_r <= 1'b0;
						in_addr_r   <= 1'b0;
						byte_act_r  <= 1'b0;
						if (in_addr_r)
						begin
							addressed_r <= addr_hit_r;
							slv_dir_r   <= sh_r[0];
						end
						if (!xmit)
							rx_data_r <= sh_r;
					end
					else if (bit_cnt_r != 4'h0)
						eng_low_r <= xmit && tx_loaded_r && !sh_r[7];
				end
				if (arb_data)
					eng_low_r <= 1'b0;
			end
		end
	end

	// sticky status flags, set wins over a software clear
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pend_r     <= 1'b0;
			arb_lost_r <= 1'b0;
		end
		else if (ce)
		begin
			if (byte_done && (ms || addressed_r || addr_hit_r) || arb_evt)
				pend_r <= 1'b1;                                    // R18
			else if (stat_wr && !pwdata[BIT_IRQ_PEND])
				pend_r <= 1'b0;                                    // R5
			if (arb_evt)
				arb_lost_r <= 1'b1;                                // R15 R17
			else if (stat_wr && !pwdata[BIT_ARB_LOST])
				arb_lost_r <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// master sequencer: START, clocking of bytes, repeated START, STOP
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			mst_r         <= M_IDLE;
			tmr_r         <= 8'h00;
			mst_scl_low_r <= 1'b0;
			mst_sda_low_r <= 1'b0;
		end
		else if (ce)
		begin
			if (tmr_r != 8'h00)
				tmr_r <= tmr_r - 8'h01;
			if (!en || arb_evt)
			begin
				// losing arbitration just lets go of both lines, no STOP
				mst_r         <= M_IDLE;                           // R7
				mst_scl_low_r <= 1'b0;
				mst_sda_low_r <= 1'b0;
			end
			else
			begin
				// start keeps sda low until scl is seen low, so the first data bit never races scl
				if (mst_r == M_LOW && !scl_s_r)
					mst_sda_low_r <= 1'b0;
				unique case (mst_r)
					M_IDLE:
						if (start_req_r && !busy_r)
						begin
							mst_sda_low_r <= 1'b1;                 // R9
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_START;
						end
					M_START:
						if (tmr_r == 8'h00)
						begin
							mst_scl_low_r <= 1'b1;
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_LOW;
						end
					M_LOW:
						if (tmr_r == 8'h00)
						begin
							if (stop_req_r)
							begin
								mst_sda_low_r <= 1'b1;             // R8
								tmr_r         <= SCL_HALF_CYC;
								mst_r         <= M_STOP1;
							end
							else if (rs_req_r)
							begin
								mst_sda_low_r <= 1'b0;             // R14
								tmr_r         <= SCL_HALF_CYC;
								mst_r         <= M_RS1;
							end
							else if (bit_cnt_r != 4'h0 || (xmit ? tx_loaded_r : rx_req_r))
							begin
								mst_scl_low_r <= 1'b0;
								tmr_r         <= SCL_HALF_CYC;
								mst_r         <= M_HIGH;
							end
						end
					M_HIGH:
						if (!scl_s_r)
							tmr_r <= SCL_HALF_CYC;                 // slave stretching
						else if (tmr_r == 8'h00)
						begin
							mst_scl_low_r <= 1'b1;
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_LOW;
						end
					M_STOP1:
						if (tmr_r == 8'h00)
						begin
							mst_scl_low_r <= 1'b0;
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_STOP2;
						end
					M_STOP2:
						if (tmr_r == 8'h00)
						begin
							mst_sda_low_r <= 1'b0;
							mst_r         <= M_IDLE;
						end
					M_RS1:
						if (tmr_r == 8'h00)
						begin
							mst_scl_low_r <= 1'b0;
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_RS2;
						end
					M_RS2:
						if (tmr_r == 8'h00)
						begin
							mst_sda_low_r <= 1'b1;
							tmr_r         <= SCL_HALF_CYC;
							mst_r         <= M_START;
						end
				endcase
			end
		end
	end

	// addressed slave holds the clock low until software serves the byte
	assign stretch = addressed_r && !ms && pend_r && !scl_s_r;

	// pin drivers and interrupt line, all registered
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			scl_oe    <= 1'b0;
			sda_oe    <= 1'b0;
			irq_r     <= 1'b0;
			sda_out_r <= 1'b0;
			scl_out_r <= 1'b0;
		end
		else if (ce)
		begin
			scl_oe <= en && (mst_scl_low_r || stretch);
			sda_oe <= en && (mst_r == M_LOW ? (eng_low_r || mst_sda_low_r) :
			                 mst_r inside {M_HIGH, M_IDLE} ? eng_low_r : mst_sda_low_r);
			irq_r  <= ie && pend_r;                                // R5 R6
		end
	end

	assign irq_req = irq_r;
	assign scl_o   = scl_out_r;
	assign sda_o   = sda_out_r;
	assign prdata  = prdata_r;
	assign pready  = pready_r;
	assign pslverr = pslverr_r;

	////////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_ms_set_wr;
		ce && ctrl_wr && en && pwdata[BIT_MOD_EN] && pwdata[BIT_MST_SEL] && !ctrl_r[BIT_MST_SEL];
	endsequence
	sequence s_ms_clr_wr;
		ce && ctrl_wr && en && !pwdata[BIT_MST_SEL] && ctrl_r[BIT_MST_SEL] && !arb_evt;
	endsequence

	a_irq_needs_both: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
		irq_req |-> $past(ie && pend_r)) else $error("irq without enable and pending");
	a_ie_keeps_pend: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
		ce && ctrl_wr && !pwdata[BIT_IRQ_EN] && pend_r |=> pend_r) else $error("pending lost");
	a_arb_drops_ms: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
		ce && arb_evt |=> !ctrl_r[BIT_MST_SEL] && mst_r == M_IDLE) else $error("master kept");
	a_ms_fall_stop: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
		s_ms_clr_wr |=> stop_req_r) else $error("no stop request");
	a_ms_rise_start: assert property (@(posedge clk_sys) disable iff (!rst_n) // R9
		s_ms_set_wr ##1 (ce && !busy_r) |=> mst_r == M_START) else $error("no start");
	a_rs_reads_zero: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
		pready && !pwrite && paddr == OFS_CONTROL |-> prdata[2:0] == 3'b000) else $error("bits 2..0 set");
	a_rs_no_owner: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
		ce && ctrl_wr && en && pwdata[BIT_RS_CMD] && !ms |=> arb_lost_r && pend_r) else $error("no loss");
	a_busy_follows: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
		ce && start_det |=> busy_r) else $error("busy not set");
	a_start_busy: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
		ce && en && mst_r == M_IDLE && start_req_r && busy_r |=> arb_lost_r) else $error("no loss");
	a_done_pend: assert property (@(posedge clk_sys) disable iff (!rst_n) // R18
		ce && byte_done && ms |=> pend_r) else $error("pending not set");
	a_off_quiet: assert property (@(posedge clk_sys) disable iff (!rst_n) // R1
		ce && !en |=> !sda_oe && !scl_oe && !irq_req) else $error("drives while off");
endmodule : icr_ctrl

// file: verilog/icr_pkg.sv
// constants shared by the bus control block: register map, field layout, reset values, timing
// assumes a 10 MHz system clock and byte-wide registers on a 32-bit APB
package icr_pkg;

	// register byte offsets on the APB window
	localparam logic [7:0] OFS_OWN_ADDR = 8'h00;
	localparam logic [7:0] OFS_CONTROL  = 8'h08;
	localparam logic [7:0] OFS_STATUS   = 8'h0C;
	localparam logic [7:0] OFS_DATA     = 8'h10;

	// control register field positions
	localparam int BIT_MOD_EN  = 7;
	localparam int BIT_IRQ_EN  = 6;
	localparam int BIT_MST_SEL = 5;
	localparam int BIT_TX_SEL  = 4;
	localparam int BIT_ACK_SUP = 3;
	localparam int BIT_RS_CMD  = 2;

	// status register field positions
	localparam int BIT_XFER_DONE = 7;
	localparam int BIT_ADDRESSED = 6;
	localparam int BIT_BUSY      = 5;
	localparam int BIT_ARB_LOST  = 4;
	localparam int BIT_SLV_DIR   = 2;
	localparam int BIT_IRQ_PEND  = 1;
	localparam int BIT_RX_ACK    = 0;

	// reset values
	localparam logic [7:0] RST_CONTROL  = 8'h00;
	localparam logic [7:0] RST_OWN_ADDR = 8'h00;

	// byte framing: eight data clocks and one acknowledge clock
	localparam logic [3:0] BITS_DATA = 4'h8;
	localparam logic [3:0] BITS_BYTE = 4'h9;

	// transmit buffer shape
	localparam int FIFO_WIDTH = 8;
	localparam int FIFO_DEPTH = 4;

	// bus clock half period in ns and in system cycles (least time, rounded up)
	localparam int CLK_PERIOD_NS = 100;
	localparam int SCL_HALF_NS   = 5000;
	localparam int SCL_HALF_INT  = (SCL_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [7:0] SCL_HALF_CYC = SCL_HALF_INT[7:0];

	// master sequencer states
	typedef enum logic [2:0] {
		M_IDLE,
		M_START,
		M_LOW,
		M_HIGH,
		M_STOP1,
		M_STOP2,
		M_RS1,
		M_RS2
	} icr_mstate_t;

endpackage : icr_pkg
